/* File: hw/irq_ctrl_consts.svh */
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets (8-bit index on the plain register port)
// ----------------------------------------------------------------
`define OFS_IRQ_CONTROL    8'h00
`define OFS_PERIPH_FLAG_A  8'h01
`define OFS_PERIPH_FLAG_B  8'h02
`define OFS_PERIPH_EN_A    8'h03
`define OFS_PERIPH_EN_B    8'h04
`define OFS_OPTION         8'h05
`define OFS_HOST_STATUS    8'h06
`define OFS_HOST_MASK      8'h07

// ----------------------------------------------------------------
// control register fields and the option register edge select bit
// ----------------------------------------------------------------
`define BIT_GLOBAL_EN      7
`define BIT_GROUP_EN       6
`define BIT_TMR_EN         5
`define BIT_EXT_EN         4
`define BIT_PCH_EN         3
`define BIT_TMR_FLAG       2
`define BIT_EXT_FLAG       1
`define BIT_PCH_FLAG       0
`define BIT_EDGE_SEL       6

// ----------------------------------------------------------------
// reset values, vector, timer maximum and peripheral count
// ----------------------------------------------------------------
`define RST_CONTROL        8'h00
`define RST_OPTION         8'hFF
`define RST_PERIPH         8'h00
`define VEC_ADDR           13'h0004
`define TMR_MAX            8'hFF
`define NUM_PERIPH         9

`endif

/* File: hw/irq_ctrl_pkg.sv */
package irq_ctrl_pkg;
  typedef enum logic [1:0] {
    ST_RUN   = 2'b00,
    ST_SLEEP = 2'b01,
    ST_WAKE  = 2'b11
  } cpu_state_e;

  typedef logic [7:0] byte_t;

  typedef struct packed {
    byte_t      ctrl;
    byte_t      pfa;
    byte_t      pfb;
    byte_t      pea;
    byte_t      peb;
    byte_t      opt;
    logic [2:0] hsts;
    logic [2:0] hmask;
    logic [1:0] ext_s;
    logic       ext_last;
    logic [3:0] port_s0;
    logic [3:0] port_s1;
    logic [3:0] port_last;
    byte_t      tmr_last;
    logic       tmr_valid;
    cpu_state_e st;
    logic       vec_req;
    logic       wake;
    logic       irq;
    byte_t      rdata;
  } ctrl_state_s;
endpackage : irq_ctrl_pkg

/* File: hw/core_interrupt_controller.sv */
// Notes on behaviour
// - flags set on their event regardless of any enable bit
// - up to twelve sources, each with own flag and enable
// - global enable bit 7 passes unmasked interrupts, blocks all when clear
// - enabled pending source with global enable set vectors at once
// - every reset clears the global enable
// - on response clear global enable, push return, jump to 0004h
// - return-from-interrupt instruction sets global enable again
// - peripheral flags/enables in two register pairs, gated by group enable
// - pin and port-change latency three or four instruction cycles
// - pin edge selected by option bit 6, sets external flag bit 1
// - external interrupt masked by its enable at control bit 4
// - external interrupt wakes from sleep if enabled, global enable picks branch
// - timer rollover FFh to 00h sets flag bit 2, enable bit 5
// - upper port nibble change sets flag bit 0 with its own enable
// - hardware saves only the return program counter
// - wake with global enable set loads vector 0004h, else next instruction
// - wake-up by enabled source happens whatever the global enable
`timescale 1ns/10ps
`include "irq_ctrl_consts.svh"

module core_interrupt_controller (
  input  wire logic                 CLK_I,
  input  wire logic                 NRST_I,
  input  wire logic [7:0]           ADDR_I,
  input  wire logic [7:0]           WDATA_I,
  input  wire logic                 WR_I,
  input  wire logic                 RD_I,
  output logic      [7:0]           RDATA_O,
  input  wire logic                 EXT_IRQ_PIN_I,
  input  wire logic [3:0]           UPPER_NIBBLE_PORT_I,
  input  wire logic [7:0]           BASIC_TIMER_COUNT_I,
  input  wire logic [`NUM_PERIPH-1:0] PERIPH_EVENT_I,
  input  wire logic                 RETURN_FROM_IRQ_INSTR_I,
  input  wire logic                 VEC_ACK_I,
  input  wire logic                 SLEEP_INSTR_I,
  output logic                      VEC_REQ_O,
  output logic      [12:0]          VEC_ADDR_O,
  output logic                      PUSH_RETURN_O,
  output logic                      WAKE_O,
  output logic                      SLEEPING_O,
  output logic                      IRQ_O
);
  import irq_ctrl_pkg::*;

  ctrl_state_s s_q;
  ctrl_state_s s_d;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    logic       ext_edge;
    logic       port_chg;
    logic       tmr_ovf;
    logic       core_pend;
    logic       per_pend;
    logic       any_pend;
    logic [7:0] pev_a;
    logic [7:0] pev_b;
    logic [2:0] hev;
    s_d       = s_q;
    ext_edge  = 1'b0;
    port_chg  = 1'b0;
    tmr_ovf   = 1'b0;
    core_pend = 1'b0;
    per_pend  = 1'b0;
    any_pend  = 1'b0;
    pev_a     = PERIPH_EVENT_I[7:0];
    pev_b     = {7'h00, PERIPH_EVENT_I[8]};
    hev       = 3'b000;

    // pin and port pass two flops; edge logic reads the second stage and its delayed copy
    s_d.ext_s    = {s_q.ext_s[0], EXT_IRQ_PIN_I};
    s_d.ext_last = s_q.ext_s[1];
    s_d.port_s0  = UPPER_NIBBLE_PORT_I;
    s_d.port_s1  = s_q.port_s0;
    s_d.port_last = s_q.port_s1;

    // edge polarity from option bit: the three-stage path gives 3-4 cycles
    if (s_q.opt[`BIT_EDGE_SEL]) begin
      ext_edge = s_q.ext_s[1] & ~s_q.ext_last;
    end else begin
      ext_edge = ~s_q.ext_s[1] & s_q.ext_last;
    end
    port_chg = |(s_q.port_s1 ^ s_q.port_last);

    // timer is on-chip logic, no sync; first sample after reset is ignored
    s_d.tmr_last  = BASIC_TIMER_COUNT_I;
    s_d.tmr_valid = 1'b1;
    tmr_ovf = s_q.tmr_valid & (s_q.tmr_last == `TMR_MAX) &
              (BASIC_TIMER_COUNT_I == 8'h00);

    // software writes first, so hardware events below win over a clear
    if (WR_I) begin
      unique case (ADDR_I)
        `OFS_IRQ_CONTROL:   s_d.ctrl = WDATA_I;
        `OFS_PERIPH_FLAG_A: s_d.pfa  = WDATA_I;
        `OFS_PERIPH_FLAG_B: s_d.pfb  = WDATA_I;
        `OFS_PERIPH_EN_A:   s_d.pea  = WDATA_I;
        `OFS_PERIPH_EN_B:   s_d.peb  = WDATA_I;
        `OFS_OPTION:        s_d.opt  = WDATA_I;
        `OFS_HOST_STATUS:   s_d.hsts = s_q.hsts & ~WDATA_I[2:0];
        `OFS_HOST_MASK:     s_d.hmask = WDATA_I[2:0];
        default: ;
      endcase
    end

    // flags set whatever the enables; set beats a same-cycle clear
    if (ext_edge) s_d.ctrl[`BIT_EXT_FLAG] = 1'b1;
    if (tmr_ovf)  s_d.ctrl[`BIT_TMR_FLAG] = 1'b1;
    if (port_chg) s_d.ctrl[`BIT_PCH_FLAG] = 1'b1;
    s_d.pfa = s_d.pfa | pev_a;
    s_d.pfb = s_d.pfb | pev_b;

    // pending terms use next-state values so a freshly written enable counts
    core_pend = (s_d.ctrl[`BIT_EXT_FLAG] & s_d.ctrl[`BIT_EXT_EN]) |
                (s_d.ctrl[`BIT_TMR_FLAG] & s_d.ctrl[`BIT_TMR_EN]) |
                (s_d.ctrl[`BIT_PCH_FLAG] & s_d.ctrl[`BIT_PCH_EN]);
    per_pend  = s_d.ctrl[`BIT_GROUP_EN] &
                (|((s_d.pfa & s_d.pea) | (s_d.pfb & s_d.peb)));
    any_pend  = core_pend | per_pend;

    // return re-arms the global enable
    if (RETURN_FROM_IRQ_INSTR_I) begin
      s_d.ctrl[`BIT_GLOBAL_EN] = 1'b1;
    end

    // sleep and wake sequencing
    s_d.wake = 1'b0;
    unique case (s_q.st)
      ST_RUN: begin
        if (SLEEP_INSTR_I & ~any_pend) begin
          s_d.st = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        if (any_pend) begin
          s_d.st   = ST_WAKE;
          s_d.wake = 1'b1;
        end
      end
      ST_WAKE: begin
        // one instruction after sleep runs before any branch
        s_d.st = ST_RUN;
      end
      // unused code 2'b10: fall back to run rather than lock up
      default: begin
        s_d.st = ST_RUN;
      end
    endcase

    // vector request out of run or wake, never from sleep, gated by global enable
    s_d.vec_req = s_d.ctrl[`BIT_GLOBAL_EN] & any_pend & (s_q.st != ST_SLEEP);

    // acknowledge: drop the global enable so no nested entry
    if (VEC_ACK_I & s_q.vec_req) begin
      s_d.ctrl[`BIT_GLOBAL_EN] = 1'b0;
      s_d.vec_req        = 1'b0;
    end

    // host-side sticky events: vector taken, wake, peripheral pending
    hev[0] = VEC_ACK_I & s_q.vec_req;
    hev[1] = s_d.wake;
    hev[2] = per_pend;
    s_d.hsts = s_d.hsts | hev;
    s_d.irq  = |(s_d.hsts & s_d.hmask);

    // read data one cycle after the strobe, zero otherwise
    s_d.rdata = 8'h00;
    if (RD_I) begin
      unique case (ADDR_I)
        `OFS_IRQ_CONTROL:   s_d.rdata = s_q.ctrl;
        `OFS_PERIPH_FLAG_A: s_d.rdata = s_q.pfa;
        `OFS_PERIPH_FLAG_B: s_d.rdata = s_q.pfb;
        `OFS_PERIPH_EN_A:   s_d.rdata = s_q.pea;
        `OFS_PERIPH_EN_B:   s_d.rdata = s_q.peb;
        `OFS_OPTION:        s_d.rdata = s_q.opt;
        `OFS_HOST_STATUS:   s_d.rdata = {5'h00, s_q.hsts};
        `OFS_HOST_MASK:     s_d.rdata = {5'h00, s_q.hmask};
        default:            s_d.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I) begin
    if (!NRST_I) begin
      s_q           <= '0;
      s_q.ctrl      <= `RST_CONTROL;
      s_q.opt       <= `RST_OPTION;
      s_q.pfa       <= `RST_PERIPH;
      s_q.pfb       <= `RST_PERIPH;
      s_q.pea       <= `RST_PERIPH;
      s_q.peb       <= `RST_PERIPH;
      s_q.st        <= ST_RUN;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops except the constant vector address and the sleep-state decode
  // ----------------------------------------------------------------
  assign RDATA_O       = s_q.rdata;
  assign VEC_REQ_O     = s_q.vec_req;
  assign VEC_ADDR_O    = `VEC_ADDR;
  assign PUSH_RETURN_O = s_q.vec_req; // only return PC is saved
  assign WAKE_O        = s_q.wake;
  assign SLEEPING_O    = (s_q.st == ST_SLEEP);
  assign IRQ_O         = s_q.irq;

endmodule : core_interrupt_controller

/* File: tb/cpu_seq_model.sv */
`timescale 1ns/10ps
// sequencer stand-in: takes the vector after one or three cycles
module cpu_seq_model (
  input  wire logic clk_i,
  input  wire logic slow_i,
  input  wire logic req_i,
  output logic      ack_o
);
  logic [1:0] cnt_q = 2'd0;
  initial ack_o = 1'b0;
  // ack only while the request stands, one cycle long
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    cnt_q <= req_i && !ack_o ? cnt_q + 2'd1 : 2'd0;
    if (req_i && !ack_o && cnt_q >= (slow_i ? 2'd2 : 2'd0)) begin
      ack_o <= 1'b1;
    end
  end
endmodule : cpu_seq_model

/* File: tb/irq_ctrl_assertions.sv */
`timescale 1ns/10ps
module irq_ctrl_assertions (
  input wire logic        CLK_I,
  input wire logic        NRST_I,
  input wire logic [7:0]  ADDR_I,
  input wire logic        RD_I,
  input wire logic        VEC_ACK_I,
  input wire logic [7:0]  RDATA_O,
  input wire logic        VEC_REQ_O,
  input wire logic [12:0] VEC_ADDR_O,
  input wire logic        PUSH_RETURN_O,
  input wire logic        WAKE_O,
  input wire logic        SLEEPING_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);
  // vector handed over to the sequencer
  sequence taken; VEC_REQ_O && VEC_ACK_I; endsequence
  a_vec_fixed: assert property (VEC_ADDR_O == 13'h0004)
    else $error("vector address moved");
  a_push_pair: assert property (PUSH_RETURN_O == VEC_REQ_O)
    else $error("push differs from request");
  a_ack_drops: assert property (taken |=> !VEC_REQ_O)
    else $error("request held after ack");
  a_sleep_quiet: assert property (SLEEPING_O |-> !VEC_REQ_O)
    else $error("request while asleep");
  a_wake_pulse: assert property (WAKE_O |=> !WAKE_O)
    else $error("wake longer than a cycle");
  a_wake_leave: assert property (WAKE_O |-> !SLEEPING_O)
    else $error("still asleep at wake");
  a_wake_source: assert property ($rose(WAKE_O) |-> $past(SLEEPING_O))
    else $error("wake without sleep");
  a_rd_idle: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data outside slot");
  a_rd_unmapped: assert property ($past(RD_I) && $past(ADDR_I) > 8'h07 |-> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
endmodule : irq_ctrl_assertions
bind core_interrupt_controller irq_ctrl_assertions chk (.CLK_I, .NRST_I, .ADDR_I, .RD_I,
  .VEC_ACK_I, .RDATA_O, .VEC_REQ_O, .VEC_ADDR_O, .PUSH_RETURN_O, .WAKE_O, .SLEEPING_O);

/* File: tb/tb.sv */
`timescale 1ns/10ps
module tb;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, pin = 0, rtn = 0, slp_i = 0, slow = 0;
  logic [7:0] addr = 0, wdata = 0, tmr = 0, rdata;
  logic [3:0] port = 0;
  logic [8:0] pev = 0;
  logic [12:0] vaddr;
  logic vreq, push, wake, slp, irq, ack, a;
  int failures = 0, num_checks = 0, n;
  always #5 clk = ~clk;
  core_interrupt_controller uut (.CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .EXT_IRQ_PIN_I(pin), .UPPER_NIBBLE_PORT_I(port),
    .BASIC_TIMER_COUNT_I(tmr), .PERIPH_EVENT_I(pev), .RETURN_FROM_IRQ_INSTR_I(rtn),
    .VEC_ACK_I(ack), .SLEEP_INSTR_I(slp_i), .VEC_REQ_O(vreq), .VEC_ADDR_O(vaddr),
    .PUSH_RETURN_O(push), .WAKE_O(wake), .SLEEPING_O(slp), .IRQ_O(irq));
  cpu_seq_model seq (.clk_i(clk), .slow_i(slow), .req_i(vreq), .ack_o(ack));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task tick(input int k); repeat (k) @(posedge clk); #1; endtask : tick
  task wreg(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk); addr <= ad; wdata <= d; wr <= 1;
    @(posedge clk); wr <= 0;
  endtask : wreg
  // read data stand only in the cycle after the strobe
  task rc(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk); addr <= ad; rd <= 1;
    @(posedge clk); rd <= 0; #1 chk(rdata, exp);
  endtask : rc
  // bounded wait; n counts edges after the launching one
  task wait_req; n = 0; while (vreq !== 1'b1 && n < 20) begin tick(1); n++; end endtask : wait_req
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task t_ext; // rising edge, vector, return
    wreg(8'h00, 8'h90); @(posedge clk); pin <= 1; wait_req;
    chk(n >= 3 && n <= 4, 1);
    chk(push, 1);
    chk(vaddr[7:0], 8'h04);
    chk({3'b000, vaddr[12:8]}, 8'h00);
    tick(3); rc(8'h00, 8'h12); chk(vreq, 0);
    wreg(8'h00, 8'h10); @(posedge clk); rtn <= 1; @(posedge clk); rtn <= 0;
    rc(8'h00, 8'h90); chk(vreq, 0);
    $display("ext done");
  endtask : t_ext
  task t_fall; // falling select; wrong edge ignored
    wreg(8'h00, 8'h00); wreg(8'h05, 8'hBF); @(posedge clk); pin <= 0; tick(5);
    rc(8'h00, 8'h02); chk(vreq, 0);
    wreg(8'h00, 8'h00); @(posedge clk); pin <= 1; tick(5); rc(8'h00, 8'h00);
    $display("fall done");
  endtask : t_fall
  task t_timer; // rollover, late ack
    @(posedge clk); tmr <= 8'hFF; @(posedge clk); tmr <= 8'h00; tick(3);
    rc(8'h00, 8'h04); slow <= 1; wreg(8'h00, 8'hA4); wait_req;
    chk(vreq, 1); tick(6); rc(8'h00, 8'h24);
    wreg(8'h00, 8'h00); @(posedge clk); port <= 4'h5; tick(5); rc(8'h00, 8'h01);
    $display("timer port done");
  endtask : t_timer
  task t_periph; // group gate
    wreg(8'h00, 8'h00); @(posedge clk); pev <= 9'h101; @(posedge clk); pev <= 0;
    rc(8'h01, 8'h01); rc(8'h02, 8'h01); wreg(8'h03, 8'h01);
    wreg(8'h00, 8'h80); tick(3); chk(vreq, 0);
    wreg(8'h00, 8'hC0); wait_req; chk(vreq, 1);
    tick(6); wreg(8'h01, 8'h00); wreg(8'h02, 8'h00); rc(8'h01, 8'h00);
    $display("periph done");
  endtask : t_periph
  task t_sleep; // wake with global enable clear
    wreg(8'h00, 8'h10); @(posedge clk); slp_i <= 1; @(posedge clk); slp_i <= 0;
    tick(2); chk(slp, 1); a = 0;
    @(posedge clk); pin <= 0;
    repeat (10) begin tick(1); if (wake === 1'b1) a = 1; end
    chk(a, 1); chk(slp, 0); chk(vreq, 0);
    $display("sleep done");
  endtask : t_sleep
  task t_irq; // host status masking and clearing
    wreg(8'h07, 8'h00); tick(2); a = irq; wreg(8'h07, 8'h07); tick(2); chk(a ^ irq, 1);
    wreg(8'h06, 8'h07); tick(2); chk(irq, 0); wreg(8'h07, 8'h00); rc(8'h06, 8'h00);
    $display("irq done");
  endtask : t_irq
  // generous bound: tests need about 150 cycles
  initial begin #200000; failures++; final_report; end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1;
    rc(8'h00, 8'h00); rc(8'h05, 8'hFF); rc(8'h20, 8'h00);
    t_ext; t_fall; t_timer; t_periph; t_sleep; t_irq;
    final_report;
  end
endmodule : tb
